/* hdl/daisy_chain_print_loop_port.v */
// Function
// - Driver mode drives shared window and clear, ignores window from others.
// - Follower mode never drives window or clear but reacts to both.
// - Isolated mode neither drives nor reacts to window or clear.
// - Each decade appears as 4-bit BCD, weights 1, 2, 4, 8.
// - Digit lines are driven only while this unit holds the turn.
// - Prepare strobe from controller readies every module for transfer.
// - Each step strobe advances one decade, most significant first.
// - Own digit transfer starts only when the incoming turn token arrives.
// - Outgoing turn token hands the transfer turn to the next unit.
// - All loop lines are bused except the point-to-point turn token.
// - Shared stop condition stops data collection in every module.
// - Only driver or controller sources clear; all but isolated respond.
// - Auto restart delay is disabled while the controller owns the loop.
// - Short record flag shows a record length other than six decades.
// - Short record flag is driven only while holding the turn.
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "print_loop_map.vh"

module daisy_chain_print_loop_port #(
  parameter MAX_DECADES = 8,
  parameter FIFO_AW     = 1
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg  [3:0]  bcd_digit_lines_out,
  output reg         bcd_digit_lines_oe,
  input  wire        transfer_prepare,
  input  wire        digit_step_strobe,
  input  wire        turn_token_in,
  output reg         turn_token_out,
  input  wire        shared_count_window_in,
  output reg         shared_count_window_out,
  output reg         shared_count_window_oe,
  input  wire        shared_clear_in,
  output reg         shared_clear_out,
  output reg         shared_clear_oe,
  input  wire        shared_stop_condition,
  input  wire        host_in_charge,
  output reg         short_record_flag_out,
  output reg         short_record_flag_oe,
  output reg         count_window,
  output reg         count_clear,
  output reg         auto_restart_active
);

  localparam S_IDLE    = 2'h0;
  localparam S_READY   = 2'h1;
  localparam S_TURN    = 2'h2;
  localparam S_RELEASE = 2'h3;
  localparam DEPTH     = 1 << FIFO_AW;
  localparam integer CLEAR_CYC_I = `CLEAR_PULSE_CYC;
  localparam [7:0] CLEAR_CYC = CLEAR_CYC_I[7:0];
  localparam [3:0] MAX_LEN   = MAX_DECADES[3:0];

  // Every loop line is foreign to pclk, so each passes two flip-flops first.
  reg  [6:0] sync1_reg;
  reg  [6:0] sync2_reg;
  reg  [2:0] last_reg;
  wire [6:0] loop_raw = {host_in_charge, shared_stop_condition, shared_clear_in,
                         shared_count_window_in, turn_token_in, digit_step_strobe,
                         transfer_prepare};
  wire prep_s   = sync2_reg[0];
  wire step_s   = sync2_reg[1];
  wire token_s  = sync2_reg[2];
  wire window_s = sync2_reg[3];
  wire clear_s  = sync2_reg[4];
  wire stop_s   = sync2_reg[5];
  wire host_s   = sync2_reg[6];
  wire prep_rise  = prep_s & ~last_reg[0];
  wire step_rise  = step_s & ~last_reg[1];
  wire token_rise = token_s & ~last_reg[2];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 7'h00;
      sync2_reg <= 7'h00;
      last_reg  <= 3'h0;
    end else begin
      sync1_reg <= loop_raw;
      sync2_reg <= sync1_reg;
      last_reg  <= sync2_reg[2:0];
    end
  end

  // Software registers.
  reg  [2:0]  ctrl_reg;
  reg  [31:0] record_reg;
  reg  [3:0]  length_reg;
  reg         collecting_reg;
  reg  [7:0]  clear_cnt_reg;
  reg  [1:0]  state_reg;
  wire [1:0]  mode = ctrl_reg[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
  wire        is_driver   = (mode == `MODE_DRIVER);
  wire        is_follower = (mode == `MODE_FOLLOWER);
  wire        wr_access = psel & penable & pready & pwrite;
  wire        cmd_wr    = wr_access & (paddr == `COMMAND_OFFSET);
  wire        addr_ok = (paddr == `CTRL_OFFSET) | (paddr == `RECORD_OFFSET) |
                        (paddr == `LENGTH_OFFSET) | (paddr == `COMMAND_OFFSET) |
                        (paddr == `STATUS_OFFSET);

  // The slave answers in the first access cycle; data and error are set up
  // at the setup edge so they come straight from flip-flops.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      prdata  <= 32'h00000000;
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          `CTRL_OFFSET:   prdata <= {29'h0, ctrl_reg};
          `RECORD_OFFSET: prdata <= record_reg;
          `LENGTH_OFFSET: prdata <= {28'h0, length_reg};
          `STATUS_OFFSET: prdata <= {24'h0, host_s, window_s, clear_s, stop_s,
                                     collecting_reg, turn_token_out, state_reg};
          default:        prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Configuration writes; writes to unmapped offsets change nothing.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= `CTRL_RESET;
      record_reg <= `RECORD_RESET;
      length_reg <= `LENGTH_RESET;
    end else if (wr_access) begin
      if (paddr == `CTRL_OFFSET)
        ctrl_reg <= pwdata[2:0];
      if (paddr == `RECORD_OFFSET)
        record_reg <= pwdata;
      if (paddr == `LENGTH_OFFSET)
        length_reg <= (pwdata[3:0] > MAX_LEN) ? MAX_LEN : pwdata[3:0];
    end
  end

  // Collection runs from a start command until a stop command or the shared
  // stop condition; a stop in the same cycle as a start wins.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      collecting_reg <= 1'b0;
    end else if (stop_s | (cmd_wr & pwdata[`CMD_STOP_BIT])) begin
      collecting_reg <= 1'b0;
    end else if (cmd_wr & pwdata[`CMD_START_BIT]) begin
      collecting_reg <= 1'b1;
    end
  end

  // A clear command is stretched so a unit sampling at the link rate sees it.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_cnt_reg <= 8'h00;
    end else if (cmd_wr & pwdata[`CMD_CLEAR_BIT]) begin
      clear_cnt_reg <= CLEAR_CYC;
    end else if (clear_cnt_reg != 8'h00) begin
      clear_cnt_reg <= clear_cnt_reg - 8'h01;
    end
  end

  // Mode steering of the shared window and clear lines and the counter side.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_count_window_out <= 1'b0;
      shared_count_window_oe  <= 1'b0;
      shared_clear_out        <= 1'b0;
      shared_clear_oe         <= 1'b0;
      count_window            <= 1'b0;
      count_clear             <= 1'b0;
      auto_restart_active     <= 1'b0;
    end else begin
      shared_count_window_out <= is_driver & collecting_reg;
      shared_count_window_oe  <= is_driver;
      shared_clear_out        <= is_driver & (clear_cnt_reg != 8'h00);
      shared_clear_oe         <= is_driver;
      // Only a follower gates its counting by the loop window.
      count_window <= collecting_reg & (~is_follower | window_s);
      // A driver obeys its own clear; a follower obeys the loop.
      count_clear  <= (is_driver & (clear_cnt_reg != 8'h00)) |
                      (is_follower & clear_s);
      auto_restart_active <= ctrl_reg[`CTRL_RESTART_BIT] & ~host_s;
    end
  end

  // Two-entry digit buffer between the record reader and the loop lines.
  // The loop controller drains it at its own pace, so the reader stalls.
  reg  [3:0]         fifo_mem [0:DEPTH-1];
  reg  [FIFO_AW-1:0] wptr_reg;
  reg  [FIFO_AW-1:0] rptr_reg;
  reg  [FIFO_AW:0]   fcount_reg;
  reg  [31:0]        snap_reg;
  reg  [3:0]         feed_left_reg;
  reg  [3:0]         sent_reg;
  reg  [3:0]         snap_len_reg;
  wire               in_valid  = (state_reg == S_TURN) & (feed_left_reg != 4'h0);
  wire               in_ready  = (fcount_reg != DEPTH[FIFO_AW:0]);
  wire               push      = in_valid & in_ready;
  wire               out_valid = (fcount_reg != {(FIFO_AW+1){1'b0}});
  wire               pop       = (state_reg == S_TURN) & step_rise & out_valid;
  wire [3:0]         feed_idx  = feed_left_reg - 4'h1;
  wire [31:0]        feed_shift = snap_reg >> {feed_idx, 2'b00};
  wire [3:0]         head      = fifo_mem[rptr_reg];
  genvar g;

  // One write port per entry.
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_entry
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          fifo_mem[g] <= 4'h0;
        else if (push & (wptr_reg == g))
          fifo_mem[g] <= feed_shift[3:0];
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_reg   <= {FIFO_AW{1'b0}};
      rptr_reg   <= {FIFO_AW{1'b0}};
      fcount_reg <= {(FIFO_AW+1){1'b0}};
    end else if (prep_rise) begin
      wptr_reg   <= {FIFO_AW{1'b0}};
      rptr_reg   <= {FIFO_AW{1'b0}};
      fcount_reg <= {(FIFO_AW+1){1'b0}};
    end else begin
      if (push)
        wptr_reg <= wptr_reg + 1'b1;
      if (pop)
        rptr_reg <= rptr_reg + 1'b1;
      if (push & ~pop)
        fcount_reg <= fcount_reg + 1'b1;
      else if (pop & ~push)
        fcount_reg <= fcount_reg - 1'b1;
    end
  end

  // Turn sequencer: prepare snapshots the record, the incoming token opens
  // the turn, steps walk the decades, and the token goes on only after the
  // lines have been let go for one cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg      <= S_IDLE;
      snap_reg       <= 32'h00000000;
      snap_len_reg   <= 4'h0;
      feed_left_reg  <= 4'h0;
      sent_reg       <= 4'h0;
      turn_token_out <= 1'b0;
    end else if (prep_rise) begin
      state_reg      <= S_READY;
      snap_reg       <= record_reg;
      snap_len_reg   <= length_reg;
      feed_left_reg  <= length_reg;
      sent_reg       <= 4'h0;
      turn_token_out <= 1'b0;
    end else begin
      case (state_reg)
        S_READY: begin
          if (token_rise)
            state_reg <= (snap_len_reg == 4'h0) ? S_RELEASE : S_TURN;
        end
        S_TURN: begin
          if (push)
            feed_left_reg <= feed_left_reg - 4'h1;
          if (pop) begin
            sent_reg <= sent_reg + 4'h1;
            if (sent_reg + 4'h1 == snap_len_reg)
              state_reg <= S_RELEASE;
          end
        end
        S_RELEASE: begin
          // The output flops lag the state by one edge, so wait until they show release.
          if (~bcd_digit_lines_oe & ~short_record_flag_oe) begin
            turn_token_out <= 1'b1;
            state_reg      <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Digit lines and short record flag exist only during the own turn.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcd_digit_lines_out   <= 4'h0;
      bcd_digit_lines_oe    <= 1'b0;
      short_record_flag_out <= 1'b0;
      short_record_flag_oe  <= 1'b0;
    end else begin
      bcd_digit_lines_out   <= (state_reg == S_TURN) ? head : 4'h0;
      bcd_digit_lines_oe    <= (state_reg == S_TURN) & out_valid;
      short_record_flag_out <= (state_reg == S_TURN) &
                               (snap_len_reg != `FULL_RECORD_LEN);
      short_record_flag_oe  <= (state_reg == S_TURN);
    end
  end

endmodule // daisy_chain_print_loop_port

/* hdl/print_loop_map.vh */
`ifndef PRINT_LOOP_MAP_VH
`define PRINT_LOOP_MAP_VH

// Register byte offsets on the APB side.
`define CTRL_OFFSET        8'h00
`define RECORD_OFFSET      8'h04
`define LENGTH_OFFSET      8'h08
`define COMMAND_OFFSET     8'h0c
`define STATUS_OFFSET      8'h10

// Reset values.
`define CTRL_RESET         3'h1
`define RECORD_RESET       32'h00000000
`define LENGTH_RESET       4'h6

// Control fields.
`define CTRL_MODE_LSB      0
`define CTRL_MODE_MSB      1
`define CTRL_RESTART_BIT   2

// Command fields, write one to act.
`define CMD_START_BIT      0
`define CMD_STOP_BIT       1
`define CMD_CLEAR_BIT      2

// Loop mode encodings.
`define MODE_ISOLATED      2'h0
`define MODE_FOLLOWER      2'h1
`define MODE_DRIVER        2'h2

// A full record holds six decades.
`define FULL_RECORD_LEN    4'h6

// Shared clear pulse width and the clock it is counted in.
`define CLEAR_PULSE_NS     320
`define CLK_PERIOD_NS      10
`define CLEAR_PULSE_CYC    ((`CLEAR_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* test/loop_chk_sva.sv */
`timescale 1ns/1ps
`include "print_loop_map.vh"
// Watches the loop pins; the mode is mirrored from APB writes to the control word.
module loop_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire        pready,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        bcd_digit_lines_oe,
  input wire        turn_token_in,
  input wire        turn_token_out,
  input wire        shared_count_window_oe,
  input wire        shared_clear_oe,
  input wire        shared_stop_condition,
  input wire        host_in_charge,
  input wire        short_record_flag_oe,
  input wire        count_window,
  input wire        count_clear,
  input wire        auto_restart_active
);
  reg [1:0] mode_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // The pins lag this mirror by one edge, so a leaving mode is allowed one cycle.
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      mode_q <= `MODE_FOLLOWER;
    else if (psel && penable && pready && pwrite && paddr == `CTRL_OFFSET)
      mode_q <= pwdata[1:0];
  // Lines drop before the token leaves.
  sequence s_handoff;
    !bcd_digit_lines_oe && !short_record_flag_oe ##1 turn_token_out;
  endsequence
  win_drive_a:
  assert property (shared_count_window_oe |-> mode_q == `MODE_DRIVER ||
    $past(mode_q) == `MODE_DRIVER) else $error("gate driven outside driver mode");
  clr_drive_a:
  assert property (shared_clear_oe |-> mode_q == `MODE_DRIVER ||
    $past(mode_q) == `MODE_DRIVER) else $error("clear driven outside driver mode");
  digit_turn_a:
  assert property (bcd_digit_lines_oe |-> turn_token_in && !turn_token_out)
    else $error("digit lines driven outside turn");
  flag_turn_a:
  assert property (short_record_flag_oe |-> turn_token_in && !turn_token_out)
    else $error("flag driven outside turn");
  tok_pass_a:
  assert property ($fell(bcd_digit_lines_oe) |-> s_handoff) else $error("bad handoff");
  tok_after_a:
  assert property ($rose(turn_token_out) |-> !$past(bcd_digit_lines_oe) &&
    !$past(short_record_flag_oe)) else $error("token passed before release");
  host_hold_a:
  assert property (host_in_charge [*5] |-> !auto_restart_active) else $error("restart on");
  stop_hold_a:
  assert property (shared_stop_condition [*5] |-> !count_window) else $error("not stopped");
  iso_clear_a:
  assert property ((mode_q == `MODE_ISOLATED) [*4] |-> !count_clear)
    else $error("isolated unit cleared");
endmodule // loop_chk
bind daisy_chain_print_loop_port loop_chk chk_u (.*);

/* test/loop_model.sv */
`timescale 1ns/1ps
// Stands in for the loop controller and the previous unit on the chain.
// The controller serves up to fifty units; this model puts the unit first in line.
module loop_model (
  input  wire [3:0] bcd_out,
  input  wire       bcd_oe,
  input  wire       flag_out,
  input  wire       flag_oe,
  input  wire       token_out,
  output reg        prepare,
  output reg        step,
  output reg        token_in,
  output reg        window,
  output reg        clear,
  output reg        stop,
  output reg        host
);
  reg       lclk;
  reg [3:0] got [0:7];
  reg       got_flag;
  reg       got_tok;
  // Frame clock out of phase with pclk; nothing moves on it outside a frame.
  initial begin
    {lclk, prepare, step, token_in, window, clear, stop, host} = 8'h00;
    #3;
    forever #80 lclk = ~lclk;
  end
  // One scan; a released line is captured as z so it never passes for data.
  task frame(input integer n);
    integer i;
    begin
      @(posedge lclk) prepare <= 1'b1;
      @(posedge lclk) prepare <= 1'b0;
      @(posedge lclk) token_in <= 1'b1;
      for (i = n - 1; i >= 0; i = i - 1) begin
        @(posedge lclk);
        got[i] = bcd_oe ? bcd_out : 4'hz;
        got_flag = flag_oe ? flag_out : 1'bz;
        step <= 1'b1;
        @(negedge lclk) step <= 1'b0;
      end
      repeat (2) @(posedge lclk);
      got_tok = token_out && !bcd_oe && !flag_oe;
      token_in <= 1'b0;
    end
  endtask
endmodule // loop_model

/* test/tb_top.sv */
`timescale 1ns/1ps
`include "print_loop_map.vh"
module tb_top;
  reg         pclk, presetn, psel, penable, pwrite, err, seen;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire [3:0]  bcd_o;
  wire        pready, pslverr, bcd_oe, prep, step, tin, tout, win_o, win_oe, clr_o, clr_oe;
  wire        stop, host, flag_o, flag_oe, cwin, cclr, arst, c_win, c_clr;
  integer     fail_count, n_checks, i, k, t;
  // Bused gate and clear: the enabled driver wins, else the controller drives.
  wire        win_w = win_oe ? win_o : c_win;
  wire        clr_w = clr_oe ? clr_o : c_clr;
  always #5 pclk = ~pclk;
  daisy_chain_print_loop_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bcd_digit_lines_out(bcd_o),
    .bcd_digit_lines_oe(bcd_oe), .transfer_prepare(prep), .digit_step_strobe(step),
    .turn_token_in(tin), .turn_token_out(tout), .shared_count_window_in(win_w),
    .shared_count_window_out(win_o), .shared_count_window_oe(win_oe),
    .shared_clear_in(clr_w), .shared_clear_out(clr_o), .shared_clear_oe(clr_oe),
    .shared_stop_condition(stop), .host_in_charge(host), .short_record_flag_out(flag_o),
    .short_record_flag_oe(flag_oe), .count_window(cwin), .count_clear(cclr),
    .auto_restart_active(arst));
  loop_model ctl_u (.bcd_out(bcd_o), .bcd_oe(bcd_oe), .flag_out(flag_o), .flag_oe(flag_oe),
    .token_out(tout), .prepare(prep), .step(step), .token_in(tin), .window(c_win),
    .clear(c_clr), .stop(stop), .host(host));
  task check(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // One APB transfer; the request holds until pready is seen at an edge.
  task apb(input wr, input [7:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      t = 0;
      @(posedge pclk);
      while (!pready && t < 20) begin
        @(posedge pclk);
        t = t + 1;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (t == 20) begin
        fail_count = fail_count + 1;
        test_done;
      end
    end
  endtask
  // Scan the record out and compare digits, flag and handoff.
  task scan(input integer n, input f);
    begin
      ctl_u.frame(n);
      for (k = 0; k < n; k = k + 1)
        check(ctl_u.got[k], (32'h87654321 >> (4 * k)) & 32'hf);
      check(ctl_u.got_flag, f);
      check(ctl_u.got_tok, 1);
    end
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = 45'h0;
    fail_count = 0;
    n_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `CTRL_OFFSET, 0);
    check(rd, `CTRL_RESET);
    apb(0, `LENGTH_OFFSET, 0);
    check(rd, `LENGTH_RESET);
    apb(0, 8'h20, 0);
    check({err, rd[30:0]}, 32'h80000000);
    apb(1, `RECORD_OFFSET, 32'h87654321);
    scan(6, 0);
    apb(1, `LENGTH_OFFSET, 32'hf);
    apb(0, `LENGTH_OFFSET, 0);
    check(rd, 8);
    scan(8, 1);
    // Each mode: driving the gate, counting gated or not, a foreign clear, a stop.
    for (i = 0; i < 3; i = i + 1) begin
      apb(1, `CTRL_OFFSET, i);
      apb(1, `COMMAND_OFFSET, 32'h1);
      repeat (6) @(posedge pclk);
      check(cwin, i != 1);
      check(win_oe, i == 2);
      check(win_o, i == 2);
      check(clr_oe, i == 2);
      ctl_u.window <= 1'b1;
      repeat (6) @(posedge pclk);
      check(cwin, 1);
      ctl_u.window <= 1'b0;
      ctl_u.clear <= 1'b1;
      seen = 0;
      for (k = 0; k < 10; k = k + 1) begin
        @(posedge pclk);
        seen = seen | cclr;
        if (k == 3)
          ctl_u.clear <= 1'b0;
      end
      check(seen, i == 1);
      ctl_u.stop <= 1'b1;
      repeat (6) @(posedge pclk);
      check(cwin, 0);
      ctl_u.stop <= 1'b0;
    end
    apb(1, `COMMAND_OFFSET, 32'h4);
    t = 0;
    repeat (60) begin
      @(posedge pclk);
      t = t + (clr_o && clr_oe);
    end
    check(t, `CLEAR_PULSE_CYC);
    apb(1, `CTRL_OFFSET, 32'h5);
    repeat (6) @(posedge pclk);
    check(arst, 1);
    ctl_u.host <= 1'b1;
    repeat (6) @(posedge pclk);
    check(arst, 0);
    test_done;
  end
endmodule // tb_top
